/* File: design/cid_bank_addr.v */
`timescale 1ns/100ps
`default_nettype none
// Register bank address: bank field picks one of four 8-byte groups
module cid_bank_addr (
   input wire [1:0] bankSelect,
   input wire [2:0] regIndex,
   output wire [7:0] ramAddr
);
   // Bank 0..3 maps to 00h,08h,10h,18h base
   assign ramAddr = {3'h0, bankSelect, regIndex};
endmodule // cid_bank_addr
`default_nettype wire

/* File: design/cid_consts.vh */
`ifndef CID_CONSTS_VH
`define CID_CONSTS_VH
// Operation classes
`define CID_OP_NONE 5'h00
`define CID_OP_ADD 5'h01
`define CID_OP_SUM_WITH_CARRY 5'h02
`define CID_OP_SUBTRACT_WITH_BORROW 5'h03
`define CID_OP_AND 5'h04
`define CID_OP_OR 5'h05
`define CID_OP_XOR 5'h06
`define CID_OP_RL 5'h07
`define CID_OP_RLC 5'h08
`define CID_OP_RR 5'h09
`define CID_OP_RRC 5'h0A
`define CID_OP_CLRA 5'h0B
`define CID_OP_CPLA 5'h0C
`define CID_OP_SWAP 5'h0D
`define CID_OP_MOV 5'h0E
`define CID_OP_MOVDP 5'h0F
`define CID_OP_XRD 5'h10
`define CID_OP_XWR 5'h11
`define CID_OP_CODEDP 5'h12
`define CID_OP_CODEPC 5'h13
`define CID_OP_PUSH 5'h14
`define CID_OP_POP 5'h15
`define CID_OP_XCH 5'h16
`define CID_OP_LOW_NIBBLE_TRADE 5'h17
`define CID_OP_INC 5'h18
`define CID_OP_DEC 5'h19
`define CID_OP_INCDP 5'h1A
`define CID_OP_MUL 5'h1B
`define CID_OP_DIV 5'h1C
`define CID_OP_DA 5'h1D
// Operand kinds
`define CID_SRC_NONE 3'h0
`define CID_SRC_ACC 3'h1
`define CID_SRC_BANK 3'h2
`define CID_SRC_DIR 3'h3
`define CID_SRC_IND 3'h4
`define CID_SRC_IMM 3'h5
`define CID_SRC_EXT 3'h6
`define CID_SRC_CODE 3'h7
// Reset values
`define CID_SP_RESET 8'h07
`define CID_PSW_RESET 8'h00
// Status word field positions
`define CID_PSW_BANK_HI 4
`define CID_PSW_BANK_LO 3
`define CID_PSW_PARITY 0
`endif

/* File: design/cid_decoder.v */
`timescale 1ns/100ps
`default_nettype none
`include "cid_consts.vh"
module cid_decoder (
   input wire clk,
   input wire nrst,
   input wire opValid,             // Opcode byte offered this cycle
   input wire [7:0] opcode,        // Fetched opcode byte
   input wire [7:0] accValue,      // Accumulator contents
   input wire [7:0] pswIn,         // Status word from core
   input wire pswLoad,             // Software write of status word
   input wire [7:0] spIn,          // Stack index write value
   input wire spLoad,              // Software write of stack index
   output wire opReady,            // Decoder idle, takes next opcode
   output reg decValid,            // Decode result valid, one pulse
   output reg [4:0] opClass,       // Operation class
   output reg [2:0] dstKind,       // Destination operand kind
   output reg [2:0] srcKind,       // Source operand kind
   output reg [1:0] instBytes,     // Instruction length in bytes
   output reg [2:0] instCycles,    // Machine cycles
   output reg [7:0] bankAddr,      // RAM address of bank register
   output reg stackWrite,          // Stack write at stackAddr
   output reg stackRead,           // Stack read at stackAddr
   output reg [7:0] stackAddr,     // Stack memory address
   output reg [7:0] stackIndex,    // Current stack index
   output reg [7:0] pswOut,        // Status word with parity one cycle behind accumulator
   output reg busy                 // Multi-cycle instruction in progress
);
   ////////////////////////////////////////////////////////////////
   // Decode table as function: {class,dst,src,bytes,cycles}
   // One table shared by the result registers and the stack process
   function [15:0] decodeOp;
      input [7:0] op;
      reg [4:0] c;
      reg [2:0] d;
      reg [2:0] s;
      reg [1:0] b;
      reg [2:0] n;
      reg [2:0] low;
      begin
         c = `CID_OP_NONE;
         d = `CID_SRC_NONE;
         s = `CID_SRC_NONE;
         b = 2'h1;
         n = 3'h1;
         // Low three bits give the common source group
         low = op[2:0];
         // Row of the opcode map picks the family
         case (op[7:4])
            4'h2, 4'h3, 4'h9, 4'h5, 4'h4, 4'h6: begin
               // Arithmetic and logic into accumulator families
               case (op[7:4])
                  4'h2: c = `CID_OP_ADD;
                  4'h3: c = `CID_OP_SUM_WITH_CARRY;
                  4'h9: c = `CID_OP_SUBTRACT_WITH_BORROW;
                  4'h5: c = `CID_OP_AND;
                  4'h4: c = `CID_OP_OR;
                  default: c = `CID_OP_XOR;
               endcase
               // Accumulator is the target unless a direct form says otherwise
               d = `CID_SRC_ACC;
               // Bit 3 set means a bank register operand
               if (op[3]) begin
                  s = `CID_SRC_BANK;
               end else begin
                  case (low)
                     3'h4: begin
                        s = `CID_SRC_IMM;
                        b = 2'h2;
                     end
                     3'h5: begin
                        s = `CID_SRC_DIR;
                        b = 2'h2;
                     end
                     3'h6, 3'h7: s = `CID_SRC_IND;
                     3'h2: begin
                        // Logic into direct from accumulator
                        d = `CID_SRC_DIR;
                        s = `CID_SRC_ACC;
                        b = 2'h2;
                     end
                     3'h3: begin
                        // Logic into direct from immediate
                        d = `CID_SRC_DIR;
                        s = `CID_SRC_IMM;
                        b = 2'h3;
                        n = 3'h2;
                     end
                     default: begin
                        // Branches and bit ops are outside this block
                        c = `CID_OP_NONE;
                        d = `CID_SRC_NONE;
                     end
                  endcase
                  // 2x/3x/9x have no direct-target forms
                  if ((low == 3'h2 || low == 3'h3) && (op[7:4] == 4'h2 || op[7:4] == 4'h3 || op[7:4] == 4'h9)) begin
                     c = `CID_OP_NONE;
                     d = `CID_SRC_NONE;
                     s = `CID_SRC_NONE;
                     b = 2'h1;
                     n = 3'h1;
                  end
               end
               // Rotates share the 23/33 slots
               if (op == 8'h23) begin
                  c = `CID_OP_RL;
                  d = `CID_SRC_ACC;
               end
               if (op == 8'h33) begin
                  c = `CID_OP_RLC;
                  d = `CID_SRC_ACC;
               end
               // 90 and 93 sit in the subtract row but are transfers;
               // without these the default branch (90) or the direct-target veto above (93) would drop them
               if (op == 8'h90) begin
                  // Load of the 16-bit pointer, constant in two bytes
                  c = `CID_OP_MOVDP;
                  d = `CID_SRC_NONE;
                  s = `CID_SRC_IMM;
                  b = 2'h3;
                  n = 3'h2;
               end
               if (op == 8'h93) begin
                  // Code byte at accumulator plus pointer
                  c = `CID_OP_CODEDP;
                  d = `CID_SRC_ACC;
                  s = `CID_SRC_CODE;
                  b = 2'h1;
                  n = 3'h2;
               end
            end
            4'h0, 4'h1: begin
               // Increment / decrement families
               c = op[4] ? `CID_OP_DEC : `CID_OP_INC;
               // Bit 3 set: bank register is both source and target
               if (op[3]) begin
                  d = `CID_SRC_BANK;
               end else begin
                  // Low three bits pick the operand; 5 to 7 as in the arithmetic rows, 4 is the accumulator, 3 a rotate
                  case (low)
                     3'h3: c = op[4] ? `CID_OP_RRC : `CID_OP_RR;
                     3'h4: d = `CID_SRC_ACC;
                     3'h5: begin
                        d = `CID_SRC_DIR;
                        b = 2'h2;
                     end
                     3'h6, 3'h7: d = `CID_SRC_IND;
                     default: c = `CID_OP_NONE;
                  endcase
                  if (low == 3'h3) begin
                     d = `CID_SRC_ACC;
                  end
               end
            end
            default: begin
               // Remaining single opcodes and transfer groups
               casez (op)
                  // Accumulator-only single byte operations
                  8'hE4: begin c = `CID_OP_CLRA; d = `CID_SRC_ACC; end
                  8'hF4: begin c = `CID_OP_CPLA; d = `CID_SRC_ACC; end
                  8'hC4: begin c = `CID_OP_SWAP; d = `CID_SRC_ACC; end
                  // Copy into the accumulator
                  8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hEF:
                     begin c = `CID_OP_MOV; d = `CID_SRC_ACC; s = `CID_SRC_BANK; end
                  8'hE5: begin c = `CID_OP_MOV; d = `CID_SRC_ACC; s = `CID_SRC_DIR; b = 2'h2; end
                  8'hE6, 8'hE7: begin c = `CID_OP_MOV; d = `CID_SRC_ACC; s = `CID_SRC_IND; end
                  8'h74: begin c = `CID_OP_MOV; d = `CID_SRC_ACC; s = `CID_SRC_IMM; b = 2'h2; end
                  // Copy into a bank register
                  8'b1111_1???: begin c = `CID_OP_MOV; d = `CID_SRC_BANK; s = `CID_SRC_ACC; end
                  8'b1010_1???: begin c = `CID_OP_MOV; d = `CID_SRC_BANK; s = `CID_SRC_DIR; b = 2'h2; n = 3'h2; end
                  8'b0111_1???: begin c = `CID_OP_MOV; d = `CID_SRC_BANK; s = `CID_SRC_IMM; b = 2'h2; end
                  // Copy into a direct byte; second byte is the address
                  8'hF5: begin c = `CID_OP_MOV; d = `CID_SRC_DIR; s = `CID_SRC_ACC; b = 2'h2; end
                  8'b1000_1???: begin c = `CID_OP_MOV; d = `CID_SRC_DIR; s = `CID_SRC_BANK; b = 2'h2; n = 3'h2; end
                  8'h86, 8'h87: begin c = `CID_OP_MOV; d = `CID_SRC_DIR; s = `CID_SRC_IND; b = 2'h2; n = 3'h2; end
                  8'h85: begin c = `CID_OP_MOV; d = `CID_SRC_DIR; s = `CID_SRC_DIR; b = 2'h3; n = 3'h2; end
                  8'h75: begin c = `CID_OP_MOV; d = `CID_SRC_DIR; s = `CID_SRC_IMM; b = 2'h3; n = 3'h2; end
                  // Copy into indirect RAM through the pointer register
                  8'hF6, 8'hF7: begin c = `CID_OP_MOV; d = `CID_SRC_IND; s = `CID_SRC_ACC; end
                  8'hA6, 8'hA7: begin c = `CID_OP_MOV; d = `CID_SRC_IND; s = `CID_SRC_DIR; b = 2'h2; n = 3'h2; end
                  8'h76, 8'h77: begin c = `CID_OP_MOV; d = `CID_SRC_IND; s = `CID_SRC_IMM; b = 2'h2; end
                  // External data: one byte, but a second bus cycle
                  8'hE2, 8'hE3, 8'hE0: begin c = `CID_OP_XRD; d = `CID_SRC_ACC; s = `CID_SRC_EXT; n = 3'h2; end
                  8'hF2, 8'hF3, 8'hF0: begin c = `CID_OP_XWR; d = `CID_SRC_EXT; s = `CID_SRC_ACC; n = 3'h2; end
                  // Code read relative to the program counter
                  8'h83: begin c = `CID_OP_CODEPC; d = `CID_SRC_ACC; s = `CID_SRC_CODE; n = 3'h2; end
                  // Stack moves; the index is handled in its own process
                  8'hC0: begin c = `CID_OP_PUSH; s = `CID_SRC_DIR; b = 2'h2; n = 3'h2; end
                  8'hD0: begin c = `CID_OP_POP; d = `CID_SRC_DIR; b = 2'h2; n = 3'h2; end
                  // Trades with the accumulator
                  8'b1100_1???: begin c = `CID_OP_XCH; d = `CID_SRC_ACC; s = `CID_SRC_BANK; end
                  8'hC5: begin c = `CID_OP_XCH; d = `CID_SRC_ACC; s = `CID_SRC_DIR; b = 2'h2; end
                  8'hC6, 8'hC7: begin c = `CID_OP_XCH; d = `CID_SRC_ACC; s = `CID_SRC_IND; end
                  8'hD6, 8'hD7: begin c = `CID_OP_LOW_NIBBLE_TRADE; d = `CID_SRC_ACC; s = `CID_SRC_IND; end
                  // Pointer bump, multiply, divide and decimal adjust
                  8'hA3: begin c = `CID_OP_INCDP; n = 3'h2; end
                  8'hA4: begin c = `CID_OP_MUL; d = `CID_SRC_ACC; n = 3'h4; end
                  8'h84: begin c = `CID_OP_DIV; d = `CID_SRC_ACC; n = 3'h4; end
                  8'hD4: begin c = `CID_OP_DA; d = `CID_SRC_ACC; end
                  // Branches, bit operations and anything unlisted
                  default: c = `CID_OP_NONE;
               endcase
            end
         endcase
         // Packed in the order the result registers unpack it
         decodeOp = {c, d, s, b, n};
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // Combinational decode and helpers
   wire [15:0] decWord; // Packed table result
   wire [7:0] bankRamAddr; // Bank register RAM address
   wire parityBit; // Live accumulator parity
   reg [2:0] cycleLeft; // Remaining machine cycles of current op
   reg [7:0] pswReg; // Held status word
   wire take; // Opcode accepted this cycle

   // Same binary encodings as the standard core
   assign decWord = decodeOp(opcode);
   // One opcode at a time; extra cycles hold off the next
   assign opReady = (cycleLeft == 3'h0);
   assign take = opValid && opReady;

   // Hazard: a status write and a bank opcode in one cycle use the old bank
   cid_bank_addr uBank (
      .bankSelect(pswReg[`CID_PSW_BANK_HI:`CID_PSW_BANK_LO]),
      .regIndex(opcode[2:0]),
      .ramAddr(bankRamAddr)
   );

   cid_parity uPar (
      .accValue(accValue),
      .parityBit(parityBit)
   );

   ////////////////////////////////////////////////////////////////
   // Decode result registers and cycle counter
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         decValid <= 1'b0;
         opClass <= `CID_OP_NONE;
         dstKind <= `CID_SRC_NONE;
         srcKind <= `CID_SRC_NONE;
         instBytes <= 2'h1;
         instCycles <= 3'h1;
         bankAddr <= 8'h00;
         cycleLeft <= 3'h0;
         busy <= 1'b0;
      end else begin
         // Decode pulse rises at the taking edge and lasts one cycle
         decValid <= take;
         // Fields hold until the next accepted opcode
         if (take) begin
            opClass <= decWord[15:11];
            dstKind <= decWord[10:8];
            srcKind <= decWord[7:5];
            instBytes <= decWord[4:3];
            instCycles <= decWord[2:0];
            bankAddr <= bankRamAddr;
            // First cycle is the decode edge itself
            cycleLeft <= decWord[2:0] - 3'h1;
            // A one-cycle op leaves the counter at zero, so ready stays up
            busy <= (decWord[2:0] != 3'h1);
         end else if (cycleLeft != 3'h0) begin
            // Count down the extra cycles; ready returns at zero
            cycleLeft <= cycleLeft - 3'h1;
            busy <= (cycleLeft != 3'h1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Stack index: pre-increment on store, post-decrement on load
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stackIndex <= `CID_SP_RESET;
         stackWrite <= 1'b0;
         stackRead <= 1'b0;
         stackAddr <= 8'h00;
      end else begin
         stackWrite <= 1'b0;
         stackRead <= 1'b0;
         // A stack op wins over a software index write
         if (take && decWord[15:11] == `CID_OP_PUSH) begin
            // Bump first so reset value 07h stores at 08h
            stackIndex <= stackIndex + 8'h01;
            // Index FFh wraps to 00h; there is no overflow flag
            stackAddr <= stackIndex + 8'h01;
            stackWrite <= 1'b1;
         end else if (take && decWord[15:11] == `CID_OP_POP) begin
            // Load reads at the current index, then steps down
            stackAddr <= stackIndex;
            stackIndex <= stackIndex - 8'h01;
            stackRead <= 1'b1;
         end else if (spLoad) begin
            // Software write loses to a stack op in the same cycle
            stackIndex <= spIn;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Status word: parity always from hardware, rest writable
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pswReg <= `CID_PSW_RESET;
         pswOut <= `CID_PSW_RESET;
      end else begin
         // Stored bits follow software writes; bit 0 is never used
         if (pswLoad) begin
            pswReg <= pswIn;
         end
         // Software cannot override parity
         // Parity trails the accumulator by one cycle; the core must allow for it
         pswOut <= {(pswLoad ? pswIn[7:1] : pswReg[7:1]), parityBit};
      end
   end
endmodule // cid_decoder
`default_nettype wire

/* File: design/cid_parity.v */
`timescale 1ns/100ps
`default_nettype none
// Parity over the accumulator for the status word
module cid_parity (
   input wire [7:0] accValue,
   output wire parityBit
);
   // Odd count of ones gives 1, so acc plus flag is even
   assign parityBit = ^accValue;
endmodule // cid_parity
`default_nettype wire

/* File: dv/cid_decoder_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module cid_decoder_asserts (
   input wire logic clk, // Core clock
   input wire logic nrst, // Async reset, active low
   input wire logic opValid,
   input wire logic [7:0] opcode,
   input wire logic [7:0] accValue,
   input wire logic opReady,
   input wire logic decValid,
   input wire logic [2:0] instCycles,
   input wire logic [7:0] bankAddr,
   input wire logic stackWrite,
   input wire logic stackRead,
   input wire logic [7:0] stackAddr,
   input wire logic [7:0] stackIndex,
   input wire logic [7:0] pswOut,
   input wire logic busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic take; // Opcode taken at this edge
   logic [4:0] bankOp; // Bank field and register index at the taking edge
   assign take = opValid && opReady;
   // Remember what the decoder saw, so the bank address can be judged a cycle later
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bankOp <= 5'h00;
      end else begin
         bankOp <= {pswOut[4:3], opcode[2:0]};
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   accept_pulse_a: assert property (take |=> decValid) else $error("decode pulse missing");
   idle_quiet_a: assert property (!take |=> !decValid) else $error("decode pulse without offer");
   ready_cycles_a: assert property (take |=> opReady == (instCycles == 3'h1)) else $error("ready vs cycles");
   busy_ready_a: assert property (busy |-> !opReady) else $error("ready while busy");
   mul_busy_a: assert property (take && opcode == 8'hA4 |=> busy [*3] ##1 !busy) else $error("product span");
   push_addr_a: assert property (take && opcode == 8'hC0 |=>
      stackWrite && stackAddr == $past(stackIndex) + 8'h01 && stackIndex == stackAddr)
      else $error("stack store address");
   pop_addr_a: assert property (take && opcode == 8'hD0 |=>
      stackRead && stackAddr == $past(stackIndex) && stackIndex == stackAddr - 8'h01)
      else $error("stack load address");
   bank_addr_a: assert property (take |=> bankAddr == {3'h0, bankOp}) else $error("bank address");
   parity_a: assert property (1'b1 |=> pswOut[0] == ^$past(accValue)) else $error("parity flag");
   // Main scenarios seen at least once
   cover property (take && opcode == 8'hC0);
   cover property (take && opcode == 8'hD0);
   cover property (take && opcode == 8'hA4);
   cover property (opValid && !opReady);
endmodule // cid_decoder_asserts
bind cid_decoder cid_decoder_asserts i_chk (.clk(clk), .nrst(nrst), .opValid(opValid), .opcode(opcode),
   .accValue(accValue), .opReady(opReady), .decValid(decValid), .instCycles(instCycles), .bankAddr(bankAddr),
   .stackWrite(stackWrite), .stackRead(stackRead), .stackAddr(stackAddr), .stackIndex(stackIndex),
   .pswOut(pswOut), .busy(busy));
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 1'b0; // 100 MHz core clock
   logic nrst = 1'b0; // Reset, active low
   logic opValid = 1'b0; // Opcode offer
   logic [7:0] opcode = 8'h00; // Offered byte
   logic [7:0] accValue = 8'h00; // Accumulator, follows the opcode
   logic [7:0] pswIn = 8'h00; // Status word write value
   logic pswLoad = 1'b0;
   logic [7:0] spIn = 8'h00; // Stack index write value
   logic spLoad = 1'b0;
   logic opReady, decValid, stackWrite, stackRead, busy; // Decoder flags
   logic [4:0] opClass;
   logic [1:0] instBytes;
   logic [2:0] instCycles, dstKind, srcKind;
   logic [7:0] bankAddr, stackAddr, stackIndex, pswOut;
   int err_total = 0; // Mismatches
   int checks = 0; // Comparisons made
   // Per range: first, last, class, bytes, cycles
   logic [31:0] tbl [78] = '{
      32'h282F0111, 32'h25250121, 32'h26270111, 32'h24240121, 32'h383F0211,
      32'h35350221, 32'h36370211, 32'h34340221, 32'h989F0311, 32'h95950321,
      32'h96970311, 32'h94940321, 32'h04041811, 32'h080F1811, 32'h05051821,
      32'h06071811, 32'hA3A31A12, 32'h14141911, 32'h181F1911, 32'h15151921,
      32'h16171911, 32'hA4A41B14, 32'h84841C14, 32'hD4D41D11, 32'h585F0411,
      32'h55550421, 32'h56570411, 32'h54540421, 32'h52520421, 32'h53530432,
      32'h484F0511, 32'h45450521, 32'h46470511, 32'h44440521, 32'h42420521,
      32'h43430532, 32'h686F0611, 32'h65650621, 32'h66670611, 32'h64640621,
      32'h62620621, 32'h63630632, 32'hE4E40B11, 32'hF4F40C11, 32'h23230711,
      32'h33330811, 32'h03030911, 32'h13130A11, 32'hC4C40D11, 32'hE8EF0E11,
      32'hE5E50E21, 32'hE6E70E11, 32'h74740E21, 32'hF8FF0E11, 32'hA8AF0E22,
      32'h787F0E21, 32'hF5F50E21, 32'h888F0E22, 32'h85850E32, 32'h86870E22,
      32'h75750E32, 32'hF6F70E11, 32'hA6A70E22, 32'h76770E21, 32'h90900F32,
      32'hE2E31012, 32'hE0E01012, 32'hF2F31112, 32'hF0F01112, 32'h93931212,
      32'h83831312, 32'hC0C01422, 32'hD0D01522, 32'hC8CF1611, 32'hC5C51621,
      32'hC6C71611, 32'hD6D71711, 32'hA5A50011};
   cid_decoder i_dut (.clk(clk), .nrst(nrst), .opValid(opValid), .opcode(opcode), .accValue(accValue),
      .pswIn(pswIn), .pswLoad(pswLoad), .spIn(spIn), .spLoad(spLoad), .opReady(opReady), .decValid(decValid),
      .opClass(opClass), .dstKind(dstKind), .srcKind(srcKind), .instBytes(instBytes), .instCycles(instCycles),
      .bankAddr(bankAddr), .stackWrite(stackWrite), .stackRead(stackRead), .stackAddr(stackAddr),
      .stackIndex(stackIndex), .pswOut(pswOut), .busy(busy));
   ////////////////////////////////////////////////////////////////////////////////
   // Single compare, every result widened to a byte
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Offer one opcode; returns just after the taking edge
   task automatic issue(input logic [7:0] op);
      @(posedge clk);
      opValid <= 1'b1;
      opcode <= op;
      accValue <= op;
      @(posedge clk);
      opValid <= 1'b0;
      #1;
   endtask
   // Count cycles until ready again, bounded so a stuck busy cannot hang us
   task automatic wait_ready(output int n);
      n = 0;
      while (opReady !== 1'b1 && n < 9) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Every listed opcode: class, length, cycles and the span of refusal
   task automatic decode_table();
      int n;
      logic [31:0] e;
      for (int i = 0; i < 78; i++) begin
         e = tbl[i];
         for (int op = e[31:24]; op <= e[23:16]; op++) begin
            issue(op[7:0]);
            chk({7'h00, decValid}, 8'h01);
            chk({3'h0, opClass}, e[15:8]);
            chk({6'h00, instBytes}, {4'h0, e[7:4]});
            chk({5'h00, instCycles}, {4'h0, e[3:0]});
            wait_ready(n);
            chk(n[7:0], {4'h0, e[3:0]} - 8'h01);
         end
      end
   endtask
   // Held offer during a product is refused, then taken when ready
   task automatic refused_during_mul();
      @(posedge clk);
      opValid <= 1'b1;
      opcode <= 8'hA4;
      @(posedge clk);
      opcode <= 8'h24;
      #1;
      chk({3'h0, opClass}, 8'h1B);
      repeat (3) begin
         @(posedge clk);
         #1;
         chk({7'h00, decValid}, 8'h00);
      end
      @(posedge clk);
      opValid <= 1'b0;
      #1;
      chk({3'h0, opClass}, 8'h01);
   endtask
   // All four banks, written status bits kept, parity bit from hardware
   task automatic bank_select();
      for (int b = 0; b < 4; b++) begin
         @(posedge clk);
         pswLoad <= 1'b1;
         pswIn <= {3'h5, b[1:0], 3'h3};
         @(posedge clk);
         pswLoad <= 1'b0;
         issue(8'h2C + b[7:0]);
         chk(bankAddr, {3'h0, b[1:0], 3'h4 + b[2:0]});
         chk(pswOut, {3'h5, b[1:0], 2'h1, ^(8'h2C + b[7:0])});
      end
   endtask
   // Store pre-increments and wraps; load reads then decrements
   task automatic stack_order();
      int n;
      @(posedge clk);
      spLoad <= 1'b1;
      spIn <= 8'hFE;
      @(posedge clk);
      spLoad <= 1'b0;
      issue(8'hC0);
      chk(stackAddr, 8'hFF);
      chk({7'h00, stackWrite}, 8'h01);
      wait_ready(n);
      issue(8'hC0);
      chk(stackIndex, 8'h00);
      wait_ready(n);
      issue(8'hD0);
      chk(stackAddr, 8'h00);
      chk(stackIndex, 8'hFF);
      chk({7'h00, stackRead}, 8'h01);
      wait_ready(n);
   endtask
   // Operand kinds: {opcode, destination, source}, codes as in the header
   task automatic operand_kinds();
      int n;
      logic [15:0] k [8] = '{16'h2812, 16'h5335, 16'hE016, 16'hF061, 16'h9317, 16'h9005, 16'h8533, 16'hF641};
      for (int i = 0; i < 8; i++) begin
         issue(k[i][15:8]);
         chk({5'h00, dstKind}, {4'h0, k[i][7:4]});
         chk({5'h00, srcKind}, {4'h0, k[i][3:0]});
         wait_ready(n);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 clk = ~clk;
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk(stackIndex, 8'h07);
      chk({6'h00, instBytes}, 8'h01);
      chk({7'h00, opReady}, 8'h01);
      decode_table();
      refused_during_mul();
      bank_select();
      operand_kinds();
      stack_order();
      tally_and_finish();
   end
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
